// ### logic/test_mode_pkg.sv
// package: constants, register map and mode codes of the production test controller
package test_mode_pkg;

  // operating mode latched when reset is released
  typedef enum logic [1:0] {
    MODE_NORMAL = 2'b00,
    MODE_ADC    = 2'b01,
    MODE_RC     = 2'b10
  } test_mode_t;

  localparam int unsigned ADDR_W   = 8;
  localparam int unsigned DATA_W   = 32;
  localparam int unsigned NIBBLE_W = 4;

  // register byte addresses
  localparam logic [ADDR_W-1:0] ADC_CTRL0_OFS = 8'h00;
  localparam logic [ADDR_W-1:0] ADC_CTRL1_OFS = 8'h04;
  localparam logic [ADDR_W-1:0] INTEG_SEL_OFS = 8'h08;
  localparam logic [ADDR_W-1:0] CLK_SEL_OFS   = 8'h0C;
  localparam logic [ADDR_W-1:0] BUZZER_OFS    = 8'h10;
  localparam logic [ADDR_W-1:0] STATUS_OFS    = 8'h14;
  localparam logic [ADDR_W-1:0] EFFECTIVE_OFS = 8'h18;

  // reset values
  localparam logic [NIBBLE_W-1:0] ADC_CTRL0_RST = 4'h0;
  localparam logic [NIBBLE_W-1:0] ADC_CTRL1_RST = 4'h1;
  localparam logic [NIBBLE_W-1:0] INTEG_SEL_RST = 4'h0;
  localparam logic                CLK_SEL_RST   = 1'b0;
  localparam logic                BUZZER_RST    = 1'b0;

  // status field positions
  localparam int unsigned ST_MODE_LSB  = 0;
  localparam int unsigned ST_COMP_BIT  = 2;
  localparam int unsigned ST_MULTI_BIT = 3;
  localparam int unsigned ST_OSC_BIT   = 4;

  // effective-control field positions
  localparam int unsigned EF_CTRL0_LSB = 0;
  localparam int unsigned EF_CTRL1_LSB = 4;
  localparam int unsigned EF_INTEG_LSB = 8;

  // integrator select positions, one-hot
  localparam int unsigned INTEG_GROUND = 0;
  localparam int unsigned INTEG_INPUT  = 1;
  localparam int unsigned INTEG_POS    = 2;
  localparam int unsigned INTEG_NEG    = 3;

endpackage

// ### logic/mode_strap_capture.sv
// strap capture: decodes test pins once after reset release and holds the mode
module mode_strap_capture
  import test_mode_pkg::*;
(
  input  wire logic clk_i,
  input  wire logic reset_i,
  input  wire logic test_select_a_i,
  input  wire logic test_select_b_i,
  input  wire logic bias_low_pin_i,
  input  wire logic crystal_in_i,
  output test_mode_t mode_o
);

  typedef struct packed {
    logic       armed;
    test_mode_t mode;
  } strap_state_t;

  strap_state_t state_q;
  strap_state_t state_d;

  // the reset pin is tied to the crystal input for the adc pattern, so after
  // release that input follows reset high and cannot be compared
  always_comb begin
    state_d = state_q;
    if (state_q.armed) begin
      state_d.armed = 1'b0;
      if (!test_select_a_i && !bias_low_pin_i && test_select_b_i) begin
        state_d.mode = MODE_ADC;
      end else if (!test_select_a_i && !test_select_b_i && !crystal_in_i) begin
        state_d.mode = MODE_RC;
      end else begin
        state_d.mode = MODE_NORMAL;
      end
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      state_q <= '{armed: 1'b1, mode: MODE_NORMAL};
    end else begin
      state_q <= state_d;
    end
  end

  assign mode_o = state_q.mode;

endmodule

// ### logic/adc_source_select.sv
// converter control source select: pins in adc test mode, software otherwise
module adc_source_select
  import test_mode_pkg::*;
#(
  parameter int unsigned CTRL_W = 4
) (
  input  wire test_mode_t        mode_i,
  input  wire logic [CTRL_W-1:0] port0_i,
  input  wire logic [CTRL_W-1:0] port1_i,
  input  wire logic [CTRL_W-1:0] port2_i,
  input  wire logic [CTRL_W-1:0] sw_ctrl0_i,
  input  wire logic [CTRL_W-1:0] sw_ctrl1_i,
  input  wire logic [CTRL_W-1:0] sw_integ_i,
  output logic      [CTRL_W-1:0] ctrl0_o,
  output logic      [CTRL_W-1:0] ctrl1_o,
  output logic      [CTRL_W-1:0] integ_o,
  output logic                   multi_sel_o
);

  logic pin_mode;

  assign pin_mode = (mode_i == MODE_ADC);

  always_comb begin
    if (pin_mode) begin
      ctrl0_o = port0_i;
      ctrl1_o = port1_i;
      integ_o = port2_i;
    end else begin
      ctrl0_o = sw_ctrl0_i;
      ctrl1_o = sw_ctrl1_i;
      integ_o = sw_integ_i;
    end
  end

  // more than one source at once shorts references inside the integrator
  assign multi_sel_o = pin_mode && ((port2_i & (port2_i - 1'b1)) != '0);

endmodule

// ### logic/test_mode_controller.sv
// top: production test controller with apb register access
////////////////////////////////////////////////////////////////////////////////
//
// Decided for this implementation: the placing of the registers and the APB register port.

module test_mode_controller
  import test_mode_pkg::*;
#(
  parameter int unsigned CTRL_W = NIBBLE_W
) (
  input  wire logic              clk_i,
  input  wire logic              reset_i,
  // apb slave
  input  wire logic              psel_i,
  input  wire logic              penable_i,
  input  wire logic              pwrite_i,
  input  wire logic [ADDR_W-1:0] paddr_i,
  input  wire logic [DATA_W-1:0] pwdata_i,
  input  wire logic [3:0]        pstrb_i,
  output logic      [DATA_W-1:0] prdata_o,
  output logic                   pready_o,
  output logic                   pslverr_o,
  // straps
  input  wire logic              test_select_a_i,
  input  wire logic              test_select_b_i,
  input  wire logic              bias_low_pin_i,
  input  wire logic              crystal_in_i,
  // port pins used as converter control in adc test mode
  input  wire logic [CTRL_W-1:0] port0_i,
  input  wire logic [CTRL_W-1:0] port1_i,
  input  wire logic [CTRL_W-1:0] port2_i,
  // analog side
  input  wire logic              comparator_out_i,
  input  wire logic              rc_clk_i,
  output logic      [CTRL_W-1:0] adc_ctrl0_o,
  output logic      [CTRL_W-1:0] adc_ctrl1_o,
  output logic      [CTRL_W-1:0] integ_sel_o,
  output logic                   rc_osc_enable_o,
  output logic                   cpu_clock_select_o,
  output logic                   buzzer_drive_pin_o,
  output logic      [1:0]        test_mode_o
);

  ////////////////////////////////////////////////////////////////////////////////
  // state

  // prdata keeps its value until the next setup, so a late look at the bus
  // still sees the last answer; pready is a one-cycle pulse and never stalls
  typedef struct packed {
    logic              pready;
    logic              pslverr;
    logic [DATA_W-1:0] prdata;
    logic [CTRL_W-1:0] sw_ctrl0;
    logic [CTRL_W-1:0] sw_ctrl1;
    logic [CTRL_W-1:0] sw_integ;
    logic              clk_sel;
    logic              buzz;
    logic [CTRL_W-1:0] ctrl0_out;
    logic [CTRL_W-1:0] ctrl1_out;
    logic [CTRL_W-1:0] integ_out;
    logic              osc_en;
    logic              buzz_pin;
    logic [1:0]        mode_out;
  } ctrl_state_t;

  ctrl_state_t state_q;
  ctrl_state_t state_d;

  test_mode_t        mode;
  logic [CTRL_W-1:0] eff_ctrl0;
  logic [CTRL_W-1:0] eff_ctrl1;
  logic [CTRL_W-1:0] eff_integ;
  logic              multi_sel;
  logic              setup_phase;
  logic              write_commit;
  logic              low_lane;

  ////////////////////////////////////////////////////////////////////////////////
  // helpers

  // one decoder serves both the error response and the write qualifier
  function automatic logic addr_mapped(input logic [ADDR_W-1:0] addr);
    logic hit;
    hit = 1'b0;
    case (addr)
      ADC_CTRL0_OFS,
      ADC_CTRL1_OFS,
      INTEG_SEL_OFS,
      CLK_SEL_OFS,
      BUZZER_OFS,
      STATUS_OFS,
      EFFECTIVE_OFS: begin
        hit = 1'b1;
      end
      default: begin
        hit = 1'b0;
      end
    endcase
    return hit;
  endfunction

  // control registers are at most one nibble wide; the upper bits of their reads are always zero
  function automatic logic [DATA_W-1:0] nibble_word(input logic [CTRL_W-1:0] val);
    logic [DATA_W-1:0] word;
    word = '0;
    word[CTRL_W-1:0] = val;
    return word;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // submodules

  // mode is the latched strap decode; test_mode_o trails it by one edge
  // because every pin of this block comes from the state register
  mode_strap_capture u_strap (
    .clk_i           (clk_i),
    .reset_i         (reset_i),
    .test_select_a_i (test_select_a_i),
    .test_select_b_i (test_select_b_i),
    .bias_low_pin_i  (bias_low_pin_i),
    .crystal_in_i    (crystal_in_i),
    .mode_o          (mode)
  );

  adc_source_select #(
    .CTRL_W (CTRL_W)
  ) u_src (
    .mode_i      (mode),
    .port0_i     (port0_i),
    .port1_i     (port1_i),
    .port2_i     (port2_i),
    .sw_ctrl0_i  (state_q.sw_ctrl0),
    .sw_ctrl1_i  (state_q.sw_ctrl1),
    .sw_integ_i  (state_q.sw_integ),
    .ctrl0_o     (eff_ctrl0),
    .ctrl1_o     (eff_ctrl1),
    .integ_o     (eff_integ),
    .multi_sel_o (multi_sel)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // apb decode

  // pslverr flags unmapped words only; writes to the read-only words and
  // writes with the low byte strobe off are dropped quietly
  assign setup_phase  = psel_i && !penable_i;
  assign write_commit = psel_i && penable_i && state_q.pready && pwrite_i && addr_mapped(paddr_i);
  // writable registers are at most one nibble wide, so only the low byte lane matters
  assign low_lane     = pstrb_i[0];

  ////////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    state_d = state_q;

    // answer with no wait state: pready rises for the access cycle only
    state_d.pready  = setup_phase;
    state_d.pslverr = 1'b0;
    if (setup_phase) begin
      state_d.pslverr = !addr_mapped(paddr_i);
      state_d.prdata  = '0;
      if (!pwrite_i) begin
        case (paddr_i)
          ADC_CTRL0_OFS: begin
            state_d.prdata = nibble_word(state_q.sw_ctrl0);
          end
          ADC_CTRL1_OFS: begin
            state_d.prdata = nibble_word(state_q.sw_ctrl1);
          end
          INTEG_SEL_OFS: begin
            state_d.prdata = nibble_word(state_q.sw_integ);
          end
          CLK_SEL_OFS: begin
            state_d.prdata[0] = state_q.clk_sel;
          end
          BUZZER_OFS: begin
            state_d.prdata[0] = state_q.buzz;
          end
          STATUS_OFS: begin
            state_d.prdata[ST_MODE_LSB +: 2] = mode;
            state_d.prdata[ST_COMP_BIT]      = comparator_out_i;
            // live, not sticky: clears as soon as the tester fixes the port 2 pins
            state_d.prdata[ST_MULTI_BIT]     = multi_sel;
            state_d.prdata[ST_OSC_BIT]       = state_q.osc_en;
          end
          EFFECTIVE_OFS: begin
            state_d.prdata[EF_CTRL0_LSB +: CTRL_W] = eff_ctrl0;
            state_d.prdata[EF_CTRL1_LSB +: CTRL_W] = eff_ctrl1;
            state_d.prdata[EF_INTEG_LSB +: CTRL_W] = eff_integ;
          end
          default: begin
            state_d.prdata = '0;
          end
        endcase
      end
    end

    // writes still land in adc test mode but are shadowed by the port pins
    if (write_commit && low_lane) begin
      case (paddr_i)
        ADC_CTRL0_OFS: begin
          state_d.sw_ctrl0 = pwdata_i[CTRL_W-1:0];
        end
        ADC_CTRL1_OFS: begin
          state_d.sw_ctrl1 = pwdata_i[CTRL_W-1:0];
        end
        INTEG_SEL_OFS: begin
          state_d.sw_integ = pwdata_i[CTRL_W-1:0];
        end
        CLK_SEL_OFS: begin
          state_d.clk_sel = pwdata_i[0];
        end
        BUZZER_OFS: begin
          state_d.buzz = pwdata_i[0];
        end
        // the read-only words take writes silently
        default: begin
          state_d.buzz = state_q.buzz;
        end
      endcase
    end

    // converter controls, one register stage from the selected source
    state_d.ctrl0_out = eff_ctrl0;
    state_d.ctrl1_out = eff_ctrl1;
    state_d.integ_out = eff_integ;
    state_d.mode_out  = mode;

    // buzzer pin source; rc clock is sampled, so 10 MHz gives one cycle jitter
    case (mode)
      MODE_ADC: begin
        state_d.buzz_pin = comparator_out_i;
        state_d.osc_en   = state_q.clk_sel;
      end
      MODE_RC: begin
        // forced on, so the tester need not set the clock select first
        state_d.buzz_pin = rc_clk_i;
        state_d.osc_en   = 1'b1;
      end
      MODE_NORMAL: begin
        state_d.buzz_pin = state_q.buzz;
        state_d.osc_en   = state_q.clk_sel;
      end
      // unused encoding: keep the pin quiet
      default: begin
        state_d.buzz_pin = 1'b0;
        state_d.osc_en   = state_q.clk_sel;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // registers

  // control outputs reset to the software reset values, so the converter sees no step
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      state_q.pready    <= 1'b0;
      state_q.pslverr   <= 1'b0;
      state_q.prdata    <= '0;
      state_q.sw_ctrl0  <= ADC_CTRL0_RST;
      state_q.sw_ctrl1  <= ADC_CTRL1_RST;
      state_q.sw_integ  <= INTEG_SEL_RST;
      state_q.clk_sel   <= CLK_SEL_RST;
      state_q.buzz      <= BUZZER_RST;
      state_q.ctrl0_out <= ADC_CTRL0_RST;
      state_q.ctrl1_out <= ADC_CTRL1_RST;
      state_q.integ_out <= INTEG_SEL_RST;
      state_q.osc_en    <= CLK_SEL_RST;
      state_q.buzz_pin  <= BUZZER_RST;
      state_q.mode_out  <= MODE_NORMAL;
    end else begin
      state_q <= state_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // outputs

  // every pin comes straight from a flop, so no decode glitch reaches the pads
  assign prdata_o           = state_q.prdata;
  assign pready_o           = state_q.pready;
  assign pslverr_o          = state_q.pslverr;
  assign adc_ctrl0_o        = state_q.ctrl0_out;
  assign adc_ctrl1_o        = state_q.ctrl1_out;
  assign integ_sel_o        = state_q.integ_out;
  assign rc_osc_enable_o    = state_q.osc_en;
  assign cpu_clock_select_o = state_q.clk_sel;
  assign buzzer_drive_pin_o = state_q.buzz_pin;
  assign test_mode_o        = state_q.mode_out;

endmodule

// ### dv/mode_rules_asserts.sv
// checker: concurrent assertions on the test controller pins
module mode_rules_checker #(
  parameter int unsigned CTRL_W = 4
) (
  input wire logic              clk_i,
  input wire logic              reset_i,
  input wire logic              test_select_a_i,
  input wire logic              test_select_b_i,
  input wire logic              bias_low_pin_i,
  input wire logic              crystal_in_i,
  input wire logic [CTRL_W-1:0] port0_i,
  input wire logic [CTRL_W-1:0] port1_i,
  input wire logic [CTRL_W-1:0] port2_i,
  input wire logic              comparator_out_i,
  input wire logic              rc_clk_i,
  input wire logic [CTRL_W-1:0] adc_ctrl0_o,
  input wire logic [CTRL_W-1:0] adc_ctrl1_o,
  input wire logic [CTRL_W-1:0] integ_sel_o,
  input wire logic              rc_osc_enable_o,
  input wire logic              buzzer_drive_pin_o,
  input wire logic [1:0]        test_mode_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);
  sequence s_adc_strap;
    $fell(reset_i) && !test_select_a_i && !bias_low_pin_i && test_select_b_i;
  endsequence
  sequence s_rc_strap;
    $fell(reset_i) && !test_select_a_i && !test_select_b_i && !crystal_in_i;
  endsequence
  // both samples in the mode, so outputs of the entry edge are not judged
  sequence s_adc_on;
    test_mode_o == 2'b01 && $past(test_mode_o) == 2'b01;
  endsequence
  sequence s_rc_on;
    test_mode_o == 2'b10 && $past(test_mode_o) == 2'b10;
  endsequence
  a_adc_entry:
    assert property (s_adc_strap |-> ##2 test_mode_o == 2'b01) else $error("adc mode not entered");
  a_rc_entry:
    assert property (s_rc_strap |-> ##2 test_mode_o == 2'b10) else $error("rc mode not entered");
  a_normal_entry:
    assert property ($fell(reset_i) && test_select_a_i |-> ##2 test_mode_o == 2'b00) else $error("bad normal start");
  a_mode_hold:
    assert property (test_mode_o != 2'b00 |=> $stable(test_mode_o)) else $error("mode changed");
  a_ctrl0_follow:
    assert property (s_adc_on |-> adc_ctrl0_o == $past(port0_i)) else $error("ctrl0 not from port0");
  a_ctrl1_follow:
    assert property (s_adc_on |-> adc_ctrl1_o == $past(port1_i)) else $error("ctrl1 not from port1");
  a_integ_follow:
    assert property (s_adc_on |-> integ_sel_o == $past(port2_i)) else $error("integ not from port2");
  a_buzz_comp:
    assert property (s_adc_on |-> buzzer_drive_pin_o == $past(comparator_out_i)) else $error("buzzer not cmp");
  a_buzz_rc:
    assert property (s_rc_on |-> buzzer_drive_pin_o == $past(rc_clk_i)) else $error("buzzer not rc clock");
  a_osc_in_rc:
    assert property (test_mode_o == 2'b10 |-> rc_osc_enable_o) else $error("oscillator off in rc mode");
endmodule

bind test_mode_controller mode_rules_checker #(.CTRL_W(CTRL_W)) i_mode_rules_checker (
  .clk_i(clk_i), .reset_i(reset_i), .test_select_a_i(test_select_a_i), .test_select_b_i(test_select_b_i),
  .bias_low_pin_i(bias_low_pin_i), .crystal_in_i(crystal_in_i), .port0_i(port0_i), .port1_i(port1_i),
  .port2_i(port2_i), .comparator_out_i(comparator_out_i), .rc_clk_i(rc_clk_i), .adc_ctrl0_o(adc_ctrl0_o),
  .adc_ctrl1_o(adc_ctrl1_o), .integ_sel_o(integ_sel_o), .rc_osc_enable_o(rc_osc_enable_o),
  .buzzer_drive_pin_o(buzzer_drive_pin_o), .test_mode_o(test_mode_o));

// ### dv/strap_tester_model.sv
// partner model: production tester straps and the on-chip rc oscillator
module strap_tester_model #(
  parameter int unsigned RC_HALF_NS = 712,
  parameter int unsigned RC_OFS_NS  = 25
) (
  input  wire logic       reset_i,
  input  wire logic [1:0] pick_i,
  input  wire logic       run_i,
  output logic            test_select_a_o,
  output logic            test_select_b_o,
  output logic            bias_low_pin_o,
  output logic            crystal_in_o,
  output logic            rc_clk_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // pick 1 asks for adc test, 2 for rc test, anything else a normal start
  assign test_select_a_o = (pick_i != 2'd1) && (pick_i != 2'd2);
  assign test_select_b_o = (pick_i == 2'd1);
  assign bias_low_pin_o  = 1'b0;
  // crystal is wired to the reset pin for adc test, so it shows the inverse of that pin's level
  assign crystal_in_o = (pick_i == 2'd1) ? ~reset_i : 1'b0;
  // an odd start offset with an even half period keeps every rc edge off the 50 ns grid,
  // so the design and the checker never race on a sample of the rc clock
  initial begin
    rc_clk_o = 1'b0;
    #(RC_OFS_NS);
    forever begin
      #(RC_HALF_NS);
      if (run_i) rc_clk_o = ~rc_clk_o;
    end
  end
endmodule

// ### dv/tb_test_mode_controller.sv
// testbench: strap entry, pin control and apb access of the test controller
module tb_test_mode_controller
  import test_mode_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk_i, reset_i, psel, penable, pwrite, pready, pslverr, er, comp, rc_clk, last;
  logic        sa, sb, bias, xtal, osc_en, cpu_sel, buzz;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0]  p0, p1, p2, ctrl0, ctrl1, integ;
  logic [1:0]  mode, pick;
  int          miscompares, tests_run, nt;

  test_mode_controller i_test_mode_controller (
    .clk_i(clk_i), .reset_i(reset_i), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
    .paddr_i(paddr), .pwdata_i(pwdata), .pstrb_i(4'hF), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .test_select_a_i(sa), .test_select_b_i(sb), .bias_low_pin_i(bias),
    .crystal_in_i(xtal), .port0_i(p0), .port1_i(p1), .port2_i(p2), .comparator_out_i(comp),
    .rc_clk_i(rc_clk), .adc_ctrl0_o(ctrl0), .adc_ctrl1_o(ctrl1), .integ_sel_o(integ),
    .rc_osc_enable_o(osc_en), .cpu_clock_select_o(cpu_sel), .buzzer_drive_pin_o(buzz), .test_mode_o(mode));

  strap_tester_model u_tester (
    .reset_i(reset_i), .pick_i(pick), .run_i(osc_en), .test_select_a_o(sa), .test_select_b_o(sb),
    .bias_low_pin_o(bias), .crystal_in_o(xtal), .rc_clk_o(rc_clk));

  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic report_and_stop();
    $display("counts: run=%0d miscompares=%0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // pready, prdata and pslverr are read at the rising edge itself, while the request still stands
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    int n;
    @(posedge clk_i);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_i);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      miscompares++;
      report_and_stop();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic do_reset(input logic [1:0] m);
    @(posedge clk_i);
    pick <= m;
    comp <= 1'b0;
    reset_i <= 1'b1;
    repeat (20) @(posedge clk_i);
    reset_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    @(negedge clk_i);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    reset_i = 1'b1;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 8'h00;
    pwdata  = 32'h0;
    pick    = 2'd1;
    comp    = 1'b0;
    p0      = 4'h0;
    p1      = 4'h0;
    p2      = 4'h0;
    do_reset(2'd1);
    chk(32'(mode), 32'h1);
    for (int i = 0; i < 4; i++) begin
      @(posedge clk_i);
      p0 <= 4'(3 * i + 1);
      p1 <= 4'(12 - i);
      // one select bit at a time keeps the integrator references apart
      p2 <= 4'h1 << i;
      comp <= i[0];
      repeat (2) @(negedge clk_i);
      chk(32'(ctrl0), 32'(3 * i + 1));
      chk(32'(ctrl1), 32'(12 - i));
      chk(32'(integ), 32'h1 << i);
      chk(32'(buzz), 32'(i % 2));
    end
    apb(ADC_CTRL0_OFS, 1'b1, 32'h5);
    repeat (2) @(negedge clk_i);
    chk(32'(ctrl0), 32'hA);
    apb(STATUS_OFS, 1'b0, 32'h0);
    chk(rd, 32'h5);
    chk(32'(er), 32'h0);
    @(posedge clk_i);
    pick <= 2'd2;
    repeat (4) @(negedge clk_i);
    chk(32'(mode), 32'h1);
    $display("test adc mode done");
    do_reset(2'd2);
    chk(32'(mode), 32'h2);
    chk(32'(osc_en), 32'h1);
    nt = 0;
    last = buzz;
    repeat (60) begin
      @(negedge clk_i);
      if (buzz !== last) nt++;
      last = buzz;
    end
    // 6 us at a 712 ns half period gives 8 or 9 edges; any divider would halve that
    chk(32'(nt >= 7 && nt <= 9), 32'h1);
    apb(STATUS_OFS, 1'b0, 32'h0);
    chk(rd, 32'h12);
    $display("test rc mode done");
    do_reset(2'd0);
    chk(32'(mode), 32'h0);
    chk(32'(ctrl1), 32'h1);
    chk(32'(osc_en), 32'h0);
    apb(ADC_CTRL0_OFS, 1'b1, 32'h9);
    repeat (3) @(negedge clk_i);
    chk(32'(ctrl0), 32'h9);
    apb(ADC_CTRL1_OFS, 1'b0, 32'h0);
    chk(rd, 32'h1);
    apb(EFFECTIVE_OFS, 1'b0, 32'h0);
    chk(rd, 32'h19);
    apb(8'h40, 1'b0, 32'h0);
    chk(32'(er), 32'h1);
    chk(rd, 32'h0);
    apb(BUZZER_OFS, 1'b1, 32'h1);
    repeat (2) @(negedge clk_i);
    chk(32'(buzz), 32'h1);
    apb(CLK_SEL_OFS, 1'b1, 32'h1);
    repeat (2) @(negedge clk_i);
    chk(32'(cpu_sel), 32'h1);
    chk(32'(osc_en), 32'h1);
    $display("test normal mode done");
    report_and_stop();
  end
endmodule
